//--- rtl/tcd_decoder.sv
`timescale 1ns/100ps
// Command byte decoder and converter function sequencer.
//
// Overview of operation
// - Top bit set starts a conversion function.
// - Top bit clear means register access command.
// - Code 0 repeats full XYZ scan until stop.
// - Code 1 repeats middle X/Y scan.
// - Code 2 converts X triplet once.
// - Code 3 converts Y triplet once.
// - Code 4 converts both pressures once.
// - Code 5 converts auxiliary input once.
// - Codes 6/7 convert middle X or Y.
// - Code 8 converts auxiliary input continuously.
// - Codes 13-15 switch on driver pairs.
// - Bias hold keeps bias on between conversions.
// - Pointer in bits six-three, direction bit zero.
// - Direction one stores pointer for reads.
// - Direction zero writes following data words.
module tcd_decoder
  import tcd_pkg::*;
#(
  parameter int unsigned DATA_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [CMD_W-1:0] cmd_byte,
  input wire logic cmd_valid,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_data_valid,
  input wire logic converter_abort,
  input wire logic pen_down,
  input wire logic conv_done,
  input wire logic bias_ready,
  output logic bias_on,
  output logic conv_start,
  output logic [SLOT_N-1:0] conv_slot,
  output logic [SLOT_N-1:0] result_update,
  output logic drv_xp,
  output logic drv_xm,
  output logic drv_yp,
  output logic drv_ym,
  output logic busy,
  output logic [3:0] active_func,
  output logic rsvd_cmd,
  output logic [3:0] read_ptr,
  output logic reg_wr_en,
  output logic [3:0] reg_wr_addr,
  output logic [DATA_W-1:0] reg_wr_data,
  output logic rsvd_bit_err
);
  tcd_state_e state_q, state_d;
  logic [3:0] func_q;
  logic repeat_q;
  logic bias_hold_on_q;
  logic [3:0] read_ptr_q;
  logic [3:0] wr_ptr_q;
  logic wr_armed_q;
  logic reg_wr_en_q;
  logic [3:0] reg_wr_addr_q;
  logic [DATA_W-1:0] reg_wr_data_q;
  logic rsvd_cmd_q;
  logic rsvd_bit_err_q;
  logic [SLOT_N-1:0] result_update_q;
  logic [3:0] drv_q;
  logic conv_start_q;
  logic [SLOT_N-1:0] slot_mask;
  // Mask of the running function, kept for repeating scans.
  logic [SLOT_N-1:0] slot_mask_q;
  logic bias_gap_q;
  logic [SLOT_N-1:0] cur;
  logic seq_empty;
  logic seq_load;
  logic seq_step;
  logic conv_cmd;
  logic acc_cmd;
  logic [3:0] func_code_bit;
  logic [3:0] reg_ptr_bit;
  logic last_slot;

  assign conv_cmd = cmd_valid && cmd_byte[CMD_KIND_BIT];
  assign acc_cmd = cmd_valid && !cmd_byte[CMD_KIND_BIT];
  assign func_code_bit = cmd_byte[FUNC_HI:FUNC_LO];
  assign reg_ptr_bit = cmd_byte[PTR_HI:PTR_LO];

  // Slot mask that each function code fills.
  always_comb begin
    slot_mask = '0;
    case (tcd_func_e'(func_code_bit))
      FN_SCAN_XYZ: begin
        slot_mask[SL_X1] = 1'b1;
        slot_mask[SL_X2] = 1'b1;
        slot_mask[SL_IX] = 1'b1;
        slot_mask[SL_Y1] = 1'b1;
        slot_mask[SL_Y2] = 1'b1;
        slot_mask[SL_IY] = 1'b1;
        slot_mask[SL_Z1] = 1'b1;
        slot_mask[SL_Z2] = 1'b1;
      end
      FN_SCAN_XY: begin
        slot_mask[SL_IX] = 1'b1;
        slot_mask[SL_IY] = 1'b1;
      end
      FN_X: begin
        slot_mask[SL_X1] = 1'b1;
        slot_mask[SL_X2] = 1'b1;
        slot_mask[SL_IX] = 1'b1;
      end
      FN_Y: begin
        slot_mask[SL_Y1] = 1'b1;
        slot_mask[SL_Y2] = 1'b1;
        slot_mask[SL_IY] = 1'b1;
      end
      FN_Z: begin
        slot_mask[SL_Z1] = 1'b1;
        slot_mask[SL_Z2] = 1'b1;
      end
      FN_AUX: slot_mask[SL_AUX] = 1'b1;
      FN_IX: slot_mask[SL_IX] = 1'b1;
      FN_IY: slot_mask[SL_IY] = 1'b1;
      FN_AUX_CONT: slot_mask[SL_AUX] = 1'b1;
      default: slot_mask = '0;
    endcase
  end

  // Slots run lowest first, so the highest mask bit is the last one.
  assign last_slot = (cur == slot_mask_q_last()) && (cur != '0);

  // A function is (re)loaded on a conversion command with a slot mask.
  assign seq_load = conv_cmd && (slot_mask != '0);
  assign seq_step = (state_q == ST_CONV) && conv_done;

  tcd_slot_seq #(
    .N(SLOT_N)
  ) u_seq (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(seq_load || (seq_step && repeat_q && last_slot)),
    .mask(seq_load ? slot_mask : slot_mask_q),
    .abort(converter_abort || (repeat_q && func_q != FN_AUX_CONT
      && !pen_down && state_q != ST_IDLE)),
    .step(seq_step),
    .cur(cur),
    .empty(seq_empty)
  );

  // Keep the mask so a repeating scan can reload it after its last slot.
  always_ff @(posedge clk) begin
    if (rst) begin
      slot_mask_q <= '0;
    end else if (ce && seq_load) begin
      slot_mask_q <= slot_mask;
    end
  end

  // Sequencer state: bias up, convert, then either next slot or idle.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (seq_load) begin
          state_d = bias_hold_on_q && bias_ready ? ST_CONV : ST_BIAS;
        end
      end
      ST_BIAS: if (bias_ready) state_d = ST_CONV;
      ST_CONV: begin
        if (conv_done) begin
          // Drop bias between conversions without hold.
          if (!bias_hold_on_q) state_d = ST_BIAS;
          if (!repeat_q && last_slot) state_d = ST_IDLE;
        end
      end
      ST_DRIVE: state_d = ST_DRIVE;
      default: state_d = ST_IDLE;
    endcase
    if (conv_cmd && func_code_bit >= FN_DRV_X) state_d = ST_DRIVE;
    if (conv_cmd && slot_mask != '0) state_d = ST_BIAS;
    if (converter_abort) state_d = ST_IDLE;
    if (repeat_q && func_q != FN_AUX_CONT && !pen_down
        && state_q != ST_IDLE && state_q != ST_DRIVE) state_d = ST_IDLE;
  end

  function automatic logic [SLOT_N-1:0] slot_mask_q_last();
    slot_mask_q_last = '0;
    for (int i = 0; i < SLOT_N; i++) begin
      if (slot_mask_q[i]) slot_mask_q_last = SLOT_N'(1) << i;
    end
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Function latch; the repeat flag marks codes 0, 1 and 8.
  always_ff @(posedge clk) begin
    if (rst) begin
      func_q <= 4'h0;
      repeat_q <= 1'b0;
      rsvd_cmd_q <= 1'b0;
    end else if (ce) begin
      if (converter_abort) begin
        repeat_q <= 1'b0;
        rsvd_cmd_q <= 1'b0;
      end else if (conv_cmd) begin
        func_q <= func_code_bit;
        repeat_q <= (func_code_bit == FN_SCAN_XYZ)
          || (func_code_bit == FN_SCAN_XY)
          || (func_code_bit == FN_AUX_CONT);
        rsvd_cmd_q <= (func_code_bit >= FN_RSV9)
          && (func_code_bit <= FN_RSV12);
      end else if (state_d == ST_IDLE) begin
        repeat_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      drv_q <= 4'h0;
    end else if (ce) begin
      if (converter_abort || (conv_cmd && func_code_bit < FN_DRV_X)) begin
        drv_q <= 4'h0;
      end else if (conv_cmd) begin
        case (tcd_func_e'(func_code_bit))
          FN_DRV_X: drv_q <= 4'b0011;
          FN_DRV_Y: drv_q <= 4'b1100;
          default: drv_q <= 4'b0110;
        endcase
      end
    end
  end
  assign drv_xp = drv_q[0];
  assign drv_xm = drv_q[1];
  assign drv_yp = drv_q[2];
  assign drv_ym = drv_q[3];

  // Conversion request and result strobes, one cycle each.
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_start_q <= 1'b0;
      result_update_q <= '0;
    end else if (ce) begin
      conv_start_q <= (state_d == ST_CONV) && (state_q != ST_CONV
        || conv_done) && !converter_abort;
      result_update_q <= seq_step ? cur : '0;
    end
  end
  assign conv_start = conv_start_q;
  assign conv_slot = cur;
  assign result_update = result_update_q;

  // One bias-off cycle after each conversion without hold.
  always_ff @(posedge clk) begin
    if (rst) begin
      bias_gap_q <= 1'b0;
    end else if (ce) begin
      bias_gap_q <= (state_q == ST_CONV) && conv_done && !bias_hold_on_q;
    end
  end

  // Bias stays on while holding and a function runs.
  assign bias_on = (state_q == ST_CONV)
    || (state_q == ST_BIAS && !bias_gap_q)
    || (bias_hold_on_q && state_q != ST_IDLE && state_q != ST_DRIVE);
  assign busy = (state_q != ST_IDLE);
  assign active_func = func_q;
  assign rsvd_cmd = rsvd_cmd_q;

  // Register access handling: pointer, bias hold and direction.
  always_ff @(posedge clk) begin
    if (rst) begin
      bias_hold_on_q <= 1'b0;
      read_ptr_q <= PTR_RESET;
      wr_ptr_q <= PTR_RESET;
      wr_armed_q <= 1'b0;
      rsvd_bit_err_q <= 1'b0;
    end else if (ce) begin
      if (acc_cmd) begin
        bias_hold_on_q <= cmd_byte[BIAS_BIT];
        rsvd_bit_err_q <= cmd_byte[RSVD_BIT];
        if (cmd_byte[DIR_BIT] == DIR_READ) begin
          read_ptr_q <= reg_ptr_bit;
          wr_armed_q <= 1'b0;
        end else begin
          wr_ptr_q <= reg_ptr_bit;
          wr_armed_q <= 1'b1;
        end
      end else if (conv_cmd) begin
        wr_armed_q <= 1'b0;
      end
    end
  end

  // Forward data words to the pointed register.
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_wr_en_q <= 1'b0;
      reg_wr_addr_q <= PTR_RESET;
      reg_wr_data_q <= '0;
    end else if (ce) begin
      reg_wr_en_q <= wr_armed_q && wr_data_valid && !cmd_valid;
      if (wr_armed_q && wr_data_valid && !cmd_valid) begin
        reg_wr_addr_q <= wr_ptr_q;
        reg_wr_data_q <= wr_data;
      end
    end
  end
  assign read_ptr = read_ptr_q;
  assign reg_wr_en = reg_wr_en_q;
  assign reg_wr_addr = reg_wr_addr_q;
  assign reg_wr_data = reg_wr_data_q;
  assign rsvd_bit_err = rsvd_bit_err_q;
endmodule

//--- include/tcd_pkg.sv
// Package with command byte fields, function codes and decoder constants.
package tcd_pkg;
  localparam int unsigned CMD_W = 8;
  localparam int unsigned CMD_KIND_BIT = 7;
  localparam int unsigned FUNC_HI = 6;
  localparam int unsigned FUNC_LO = 3;
  localparam int unsigned PTR_HI = 6;
  localparam int unsigned PTR_LO = 3;
  localparam int unsigned RSVD_BIT = 2;
  localparam int unsigned BIAS_BIT = 1;
  localparam int unsigned DIR_BIT = 0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [3:0] PTR_RESET = 4'h0;

  // Result register slots, one bit each in the update mask.
  localparam int unsigned SLOT_N = 10;
  localparam int unsigned SL_X1 = 0;
  localparam int unsigned SL_X2 = 1;
  localparam int unsigned SL_Y1 = 2;
  localparam int unsigned SL_Y2 = 3;
  localparam int unsigned SL_IX = 4;
  localparam int unsigned SL_IY = 5;
  localparam int unsigned SL_Z1 = 6;
  localparam int unsigned SL_Z2 = 7;
  localparam int unsigned SL_AUX = 9;

  typedef enum logic [3:0] {
    FN_SCAN_XYZ = 4'b0000,
    FN_SCAN_XY = 4'b0001,
    FN_X = 4'b0010,
    FN_Y = 4'b0011,
    FN_Z = 4'b0100,
    FN_AUX = 4'b0101,
    FN_IX = 4'b0110,
    FN_IY = 4'b0111,
    FN_AUX_CONT = 4'b1000,
    FN_RSV9 = 4'b1001,
    FN_RSV10 = 4'b1010,
    FN_RSV11 = 4'b1011,
    FN_RSV12 = 4'b1100,
    FN_DRV_X = 4'b1101,
    FN_DRV_Y = 4'b1110,
    FN_DRV_YX = 4'b1111
  } tcd_func_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BIAS = 2'b01,
    ST_CONV = 2'b10,
    ST_DRIVE = 2'b11
  } tcd_state_e;
endpackage

//--- rtl/tcd_slot_seq.sv
`timescale 1ns/100ps
// Walks a slot mask lowest bit first, one conversion request per slot.
module tcd_slot_seq
  import tcd_pkg::*;
#(
  parameter int unsigned N = SLOT_N
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [N-1:0] mask,
  input wire logic abort,
  input wire logic step,
  output logic [N-1:0] cur,
  output logic empty
);
  logic [N-1:0] pend_q;

  // Lowest pending slot, isolated as a one-hot vector.
  assign cur = pend_q & (~pend_q + {{(N-1){1'b0}}, 1'b1});
  assign empty = (pend_q == '0);

  // Load wins over step so a restart never loses the fresh mask.
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q <= '0;
    end else if (ce) begin
      if (abort) begin
        pend_q <= '0;
      end else if (load) begin
        pend_q <= mask;
      end else if (step) begin
        pend_q <= pend_q & ~cur;
      end
    end
  end
endmodule

//--- bench/tcd_conv_model.sv
// Converter front-end model that answers bias and conversion requests.
`timescale 1ns/100ps
module tcd_conv_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic bias_on,
  input wire logic conv_start,
  input wire logic slow,
  output logic bias_ready,
  output logic conv_done
);
  logic rdy_q;
  logic [3:0] cnt_q;
  // bias settling.
  // Ready drops at once with the bias, so a stale ready is never seen.
  always_ff @(posedge clk) begin
    rdy_q <= !rst && bias_on;
  end
  assign bias_ready = rdy_q && bias_on;
  // conversion time.
  // Slow mode stretches each conversion to stress the wait states.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else if (conv_start) begin
      cnt_q <= slow ? 4'h9 : 4'h2;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign conv_done = cnt_q == 4'h1;
endmodule

//--- bench/tcd_decoder_assertions.sv
// Concurrent checks on the command decoder ports.
`timescale 1ns/100ps
module tcd_decoder_chk
  import tcd_pkg::*;
#(
  parameter int unsigned DATA_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [CMD_W-1:0] cmd_byte,
  input wire logic cmd_valid,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_data_valid,
  input wire logic converter_abort,
  input wire logic conv_done,
  input wire logic bias_ready,
  input wire logic conv_start,
  input wire logic [SLOT_N-1:0] result_update,
  input wire logic drv_xp,
  input wire logic drv_xm,
  input wire logic drv_yp,
  input wire logic drv_ym,
  input wire logic rsvd_cmd,
  input wire logic [3:0] read_ptr,
  input wire logic reg_wr_en,
  input wire logic [DATA_W-1:0] reg_wr_data,
  input wire logic rsvd_bit_err
);
  logic tk;
  logic acc;
  // A command counts only when taken and not overridden by an abort.
  assign tk = cmd_valid && ce && !converter_abort;
  assign acc = tk && !cmd_byte[CMD_KIND_BIT];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  drv_pair_a: assert property (tk && cmd_byte == 8'he8 |=>
    drv_xp && drv_xm && !drv_yp && !drv_ym) else $error("x drivers wrong");
  read_ptr_a: assert property (acc && cmd_byte[DIR_BIT] |=>
    read_ptr == $past(cmd_byte[PTR_HI:PTR_LO])) else $error("read ptr");
  rsvd_flag_a: assert property (tk && cmd_byte[7:3] inside {[5'h19:5'h1c]}
    |=> rsvd_cmd) else $error("reserved flag");
  abort_clear_a: assert property (converter_abort && ce |=> !rsvd_cmd)
    else $error("abort clear");
  wr_pair_a: assert property (reg_wr_en |-> $past(wr_data_valid) &&
    reg_wr_data == $past(wr_data)) else $error("write pairing");
  upd_cause_a: assert property (result_update != '0 |->
    $past(conv_done) && $onehot(result_update)) else $error("update");
  start_cause_a: assert property (conv_start |-> $past(bias_ready))
    else $error("start before bias");
  bit_err_a: assert property (acc |=>
    rsvd_bit_err == $past(cmd_byte[RSVD_BIT])) else $error("bit two flag");
endmodule
bind tcd_decoder tcd_decoder_chk #(.DATA_W(DATA_W)) i_chk (.clk(clk),
  .rst(rst), .ce(ce), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
  .wr_data(wr_data), .wr_data_valid(wr_data_valid),
  .converter_abort(converter_abort), .conv_done(conv_done),
  .bias_ready(bias_ready), .conv_start(conv_start),
  .result_update(result_update), .drv_xp(drv_xp), .drv_xm(drv_xm),
  .drv_yp(drv_yp), .drv_ym(drv_ym), .rsvd_cmd(rsvd_cmd),
  .read_ptr(read_ptr), .reg_wr_en(reg_wr_en),
  .reg_wr_data(reg_wr_data), .rsvd_bit_err(rsvd_bit_err));

//--- bench/testbench.sv
// Self-checking bench for the command decoder.
`timescale 1ns/100ps
module testbench
  import tcd_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] cmd_byte = 8'h00;
  logic cmd_valid = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic wr_data_valid = 1'b0;
  logic converter_abort = 1'b0;
  logic pen_down = 1'b1;
  logic slow = 1'b0;
  logic conv_done, bias_ready, bias_on, conv_start, busy, rsvd_cmd;
  logic drv_xp, drv_xm, drv_yp, drv_ym, reg_wr_en, rsvd_bit_err;
  logic [9:0] conv_slot, result_update, seen, seen_slot;
  logic [3:0] active_func, read_ptr, reg_wr_addr, ptr;
  logic [15:0] reg_wr_data, wd;
  logic hold;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int lows;
  always #10 clk = ~clk;
  tcd_conv_model i_conv (.clk(clk), .rst(rst), .bias_on(bias_on),
    .conv_start(conv_start), .slow(slow), .bias_ready(bias_ready),
    .conv_done(conv_done));
  tcd_decoder i_dut (.clk(clk), .rst(rst), .ce(ce), .cmd_byte(cmd_byte),
    .cmd_valid(cmd_valid), .wr_data(wr_data), .wr_data_valid(wr_data_valid),
    .converter_abort(converter_abort), .pen_down(pen_down),
    .conv_done(conv_done), .bias_ready(bias_ready), .bias_on(bias_on),
    .conv_start(conv_start), .conv_slot(conv_slot),
    .result_update(result_update), .drv_xp(drv_xp), .drv_xm(drv_xm),
    .drv_yp(drv_yp), .drv_ym(drv_ym), .busy(busy),
    .active_func(active_func), .rsvd_cmd(rsvd_cmd), .read_ptr(read_ptr),
    .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .rsvd_bit_err(rsvd_bit_err));
  // Slots each function code is expected to refresh.
  function automatic logic [9:0] exp_mask(input int c);
    case (c)
      0: return 10'h0ff;
      1: return 10'h030;
      2: return 10'h013;
      3: return 10'h02c;
      4: return 10'h0c0;
      6: return 10'h010;
      7: return 10'h020;
      default: return 10'h200;
    endcase
  endfunction
  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Every pulse lasts one cycle and is launched at a falling edge.
  task automatic send(input logic [7:0] b, input logic ab);
    @(negedge clk);
    cmd_byte = b;
    cmd_valid = !ab;
    converter_abort = ab;
    @(negedge clk);
    cmd_valid = 1'b0;
    converter_abort = 1'b0;
  endtask
  // Gathers updates, requested slots and bias-off cycles while busy.
  task automatic watch(input int n, input logic idle);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      seen |= result_update;
      if (conv_start === 1'b1) seen_slot |= conv_slot;
      if (busy === 1'b1 && bias_on !== 1'b1) lows++;
      if (idle && busy === 1'b0) break;
    end
  endtask
  // A hang ends the run as a failure.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(98853));
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int c = 0; c < 9; c++) begin
      hold = 1'($urandom);
      ptr = 4'($urandom);
      slow = 1'($urandom);
      send({1'b0, ptr, 1'b0, hold, DIR_READ}, 1'b0);
      chk("read_ptr", 16'(ptr), 16'(read_ptr));
      chk("busy_acc", 16'h0, 16'(busy));
      seen = '0;
      seen_slot = '0;
      lows = 0;
      send({1'b1, c[3:0], 3'b000}, 1'b0);
      watch(300, 1'b0);
      if (c < 2) pen_down = 1'b0;
      if (c == 8) send(8'h00, 1'b1);
      watch(400, 1'b1);
      chk("busy_end", 16'h0, 16'(busy));
      chk("updates", 16'(exp_mask(c)), 16'(seen));
      chk("slots", 16'(exp_mask(c)), 16'(seen_slot));
      chk("func", 16'(c), 16'(active_func));
      if (hold) chk("bias_lows", 16'h0, 16'(lows));
      if (!hold && (c < 5 || c == 8))
        chk("bias_gaps", 16'h1, 16'(lows != 0));
      pen_down = 1'b1;
    end
    for (int c = 13; c < 16; c++) begin
      send({1'b1, c[3:0], 3'b000}, 1'b0);
      chk("drivers", c == 13 ? 16'hc : c == 14 ? 16'h3 : 16'h6,
        16'({drv_xp, drv_xm, drv_yp, drv_ym}));
    end
    send(8'h00, 1'b1);
    chk("drv_clear", 16'h0, 16'({drv_xp, drv_xm, drv_yp, drv_ym}));
    chk("drv_idle", 16'h0, 16'(busy));
    for (int c = 9; c < 13; c++) begin
      send({1'b1, c[3:0], 3'b000}, 1'b0);
      chk("rsvd_set", 16'h1, 16'(rsvd_cmd));
      chk("rsvd_busy", 16'h0, 16'(busy));
      send(8'h00, 1'b1);
      chk("rsvd_clr", 16'h0, 16'(rsvd_cmd));
    end
    repeat (6) begin
      ptr = 4'($urandom);
      wd = 16'($urandom);
      send({1'b0, ptr, 3'b000}, 1'b0);
      wr_data = wd;
      wr_data_valid = 1'b1;
      @(negedge clk);
      wr_data_valid = 1'b0;
      chk("wr_en", 16'h1, 16'(reg_wr_en));
      chk("wr_addr", 16'(ptr), 16'(reg_wr_addr));
      chk("wr_data", wd, reg_wr_data);
    end
    wrap_up();
  end
endmodule
